// ===== frac_div.sv
// Fractional 100 us divider: tick spacing 19, 19, 19, 18.
`include "interval_tick_timer_regs.svh"
`default_nettype none
module frac_div (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic tick,
	output logic pulse
);
	logic [4:0] cnt_reg;
	logic [1:0] phase_reg;
	wire [4:0] term = (phase_reg == `ITT_SHORT_PHASE) ? `ITT_SHORT_TICKS - 5'h01 : `ITT_LONG_TICKS - 5'h01;
	wire at_end = cnt_reg >= term;
	assign pulse = tick & at_end & ~clear;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			phase_reg <= '0;
		end else if (clear) begin
			cnt_reg <= '0;
			phase_reg <= '0;
		end else if (tick) begin
			cnt_reg <= at_end ? 5'h00 : cnt_reg + 5'h01;
			phase_reg <= at_end ? phase_reg + 2'h1 : phase_reg;
		end
	end
endmodule : frac_div
`default_nettype wire

// ===== interval_tick_timer.sv
// Interval tick timer with APB register access and interrupt.
// How it works
// - A tick is made at the oscillator rate over 128, whatever the system clock division.
// - The tick counter runs on the divided clock and its terminal count follows the division.
// - A three-bit select picks off, 100 us, 200 us, 400 us, 800 us, 1 ms, 2 ms or 5 ms.
// - The 100 us interval spaces pulses 19, 19, 19 then 18 ticks apart.
// - The 200 us interval alternates 38 and 37 ticks.
// - Intervals of 400 us, 800 us and 2 ms are evenly spaced; 1 ms and 5 ms alternate by one tick.
// - The flag in bit 7 is set per interval, never cleared by hardware, cleared by writing zero.
// - Enabling resumes the tick and lower divider from where they held; the upper stage runs from select 3 up.
// - The tick only runs while the enable bit is one.
// - Writing one to bit 5 clears the interval divider, which keeps running, and leaves the tick alone.
// - Writing one to the tick-clear bit of the clock generator register clears the tick counter only.
// - Control bits 4 and 3 read as zero and ignore writes.
// - The tick and the 100 us pulse leave as single-cycle enables on the system clock.
//
// The APB interface to the registers was decided locally.
`include "interval_tick_timer_regs.svh"
`default_nettype none
module interval_tick_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ITT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic tick_pulse,
	output logic pulse_100us
);
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// The access phase takes two cycles; the second has pready high.
	wire setup_done = psel & penable & ~pready;
	wire acc = psel & penable & pready;
	wire wr_acc = acc & pwrite & pstrb[0];
	wire hit_ctrl = paddr == `ITT_CTRL_OFS;
	wire hit_sys = paddr == `ITT_SYSTEM_CLOCK_GENERATOR_CONTROL_OFS;
	wire hit_stat = paddr == `ITT_STAT_OFS;
	wire hit_mask = paddr == `ITT_MASK_OFS;
	wire hit_any = hit_ctrl | hit_sys | hit_stat | hit_mask;
	wire ctrl_wr = wr_acc & hit_ctrl;
	wire sys_wr = wr_acc & hit_sys;
	wire mask_wr = wr_acc & hit_mask;
	wire stat_rd = acc & ~pwrite & hit_stat;

	// ------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------
	logic flag_reg;
	logic en_reg;
	interval_tick_timer_pkg::interval_sel_t sel_reg;
	logic [2:0] div_reg;
	logic [`ITT_EV_W-1:0] stat_reg;
	logic [`ITT_EV_W-1:0] mask_reg;
	logic pair_reg;
	logic [4:0] unit_reg;
	logic [6:0] upper_reg;

	wire cnt_clear = ctrl_wr & pwdata[`ITT_CLR_BIT];
	wire tick_clear = sys_wr & pwdata[`ITT_TICKCLR_BIT];
	wire en_next = ctrl_wr ? pwdata[`ITT_EN_BIT] : en_reg;
	wire [2:0] sel_wdata = pwdata[`ITT_SEL_MSB:`ITT_SEL_LSB];
	wire [2:0] div_next = sys_wr ? pwdata[`ITT_DIV_MSB:`ITT_DIV_LSB] : div_reg;

	// ------------------------------------------------------------
	// Tick and 100 us stages
	// ------------------------------------------------------------
	logic tick;
	logic [1:0] half_step;
	logic p100;

	tick_gen #(
		.CNT_W(7)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(en_reg),
		.clear(tick_clear),
		.div_sel(div_reg),
		.tick(tick),
		.half_step(half_step)
	);

	// The tick only advances while enabled, so this stage holds when disabled.
	frac_div u_frac (
		.pclk(pclk),
		.presetn(presetn),
		.clear(cnt_clear),
		.tick(tick),
		.pulse(p100)
	);

	// ------------------------------------------------------------
	// Upper stage
	// ------------------------------------------------------------
	// Counts units of 25 half ticks; every long interval is a whole number of them.
	wire upper_run = en_reg && (sel_reg >= interval_tick_timer_pkg::SEL_400US);
	wire [5:0] unit_sum = {1'b0, unit_reg} + {4'h0, half_step};
	wire unit_wrap = unit_sum >= `ITT_UNIT_HALF_TICKS;
	wire [5:0] unit_left = unit_wrap ? unit_sum - `ITT_UNIT_HALF_TICKS : unit_sum;
	wire [6:0] lim_400 = 7'(`ITT_IVL_400_US * `ITT_UNIT_DEN / `ITT_UNIT_NUM_US);
	wire [6:0] lim_800 = 7'(`ITT_IVL_800_US * `ITT_UNIT_DEN / `ITT_UNIT_NUM_US);
	wire [6:0] lim_1ms = 7'(`ITT_IVL_1MS_US * `ITT_UNIT_DEN / `ITT_UNIT_NUM_US);
	wire [6:0] lim_2ms = 7'(`ITT_IVL_2MS_US * `ITT_UNIT_DEN / `ITT_UNIT_NUM_US);
	wire [6:0] lim_5ms = 7'(`ITT_IVL_5MS_US * `ITT_UNIT_DEN / `ITT_UNIT_NUM_US);
	wire [6:0] upper_lim =
		(sel_reg == interval_tick_timer_pkg::SEL_400US) ? lim_400 :
		(sel_reg == interval_tick_timer_pkg::SEL_800US) ? lim_800 :
		(sel_reg == interval_tick_timer_pkg::SEL_1MS) ? lim_1ms :
		(sel_reg == interval_tick_timer_pkg::SEL_2MS) ? lim_2ms : lim_5ms;
	wire [6:0] upper_last = upper_lim - 7'h01;
	wire up_end = upper_run & unit_wrap & (upper_reg >= upper_last);

	// ------------------------------------------------------------
	// Interval pulse and flag
	// ------------------------------------------------------------
	// Pairs of 100 us periods give the 38 and 37 tick alternation.
	wire hit_100 = (sel_reg == interval_tick_timer_pkg::SEL_100US) & p100;
	wire hit_200 = (sel_reg == interval_tick_timer_pkg::SEL_200US) & p100 & pair_reg;
	wire ivl_hit = en_reg & (hit_100 | hit_200 | up_end);
	// A set in the same cycle as a software clear wins.
	wire flag_next = ivl_hit | (ctrl_wr ? flag_reg & pwdata[`ITT_FLAG_BIT] : flag_reg);

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	wire [`ITT_EV_W-1:0] events = {p100, ivl_hit};
	// Only bits that were returned by the read are cleared.
	wire [`ITT_EV_W-1:0] stat_clr = stat_rd ? prdata[`ITT_EV_W-1:0] : '0;
	wire [`ITT_EV_W-1:0] stat_next = (stat_reg & ~stat_clr) | events;
	wire [`ITT_EV_W-1:0] mask_next = mask_wr ? pwdata[`ITT_EV_W-1:0] : mask_reg;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	wire [7:0] ctrl_rd = {flag_reg, en_reg, 1'b0, 2'b00, sel_reg};
	wire [31:0] rd_mux =
		hit_ctrl ? {24'h000000, ctrl_rd} :
		hit_sys ? {29'h00000000, div_reg} :
		hit_stat ? {30'h00000000, stat_reg} :
		hit_mask ? {30'h00000000, mask_reg} : 32'h00000000;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup_done;
			pslverr <= setup_done & ~hit_any;
			prdata <= (setup_done & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= 1'(`ITT_CTRL_RESET >> `ITT_FLAG_BIT);
			en_reg <= 1'b0;
			sel_reg <= interval_tick_timer_pkg::SEL_OFF;
			div_reg <= `ITT_SYSTEM_CLOCK_GENERATOR_CONTROL_RESET;
		end else begin
			flag_reg <= flag_next;
			en_reg <= en_next;
			sel_reg <= ctrl_wr ? interval_tick_timer_pkg::interval_sel_t'(sel_wdata) : sel_reg;
			div_reg <= div_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_reg <= 1'b0;
			unit_reg <= 5'h00;
			upper_reg <= 7'h00;
		end else if (cnt_clear) begin
			pair_reg <= 1'b0;
			unit_reg <= 5'h00;
			upper_reg <= 7'h00;
		end else begin
			pair_reg <= p100 ? ~pair_reg : pair_reg;
			unit_reg <= upper_run ? unit_left[4:0] : unit_reg;
			upper_reg <= (upper_run & unit_wrap) ? (up_end ? 7'h00 : upper_reg + 7'h01) : upper_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= '0;
			mask_reg <= '0;
			irq <= 1'b0;
			tick_pulse <= 1'b0;
			pulse_100us <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			irq <= |(stat_reg & mask_reg);
			tick_pulse <= tick;
			pulse_100us <= p100;
		end
	end
endmodule : interval_tick_timer
`default_nettype wire

// ===== interval_tick_timer_pkg.sv
// Types shared by the interval tick timer files.
`default_nettype none
package interval_tick_timer_pkg;
	typedef enum logic [2:0] {
		SEL_OFF = 3'h0,
		SEL_100US = 3'h1,
		SEL_200US = 3'h2,
		SEL_400US = 3'h3,
		SEL_800US = 3'h4,
		SEL_1MS = 3'h5,
		SEL_2MS = 3'h6,
		SEL_5MS = 3'h7
	} interval_sel_t;
endpackage : interval_tick_timer_pkg
`default_nettype wire

// ===== interval_tick_timer_regs.svh
// Register offsets, field positions and counts of the interval tick timer.
`ifndef INTERVAL_TICK_TIMER_REGS_SVH
`define INTERVAL_TICK_TIMER_REGS_SVH
`define ITT_ADDR_W 12
`define ITT_CTRL_OFS 12'h09C
`define ITT_SYSTEM_CLOCK_GENERATOR_CONTROL_OFS 12'h0A0
`define ITT_STAT_OFS 12'h0A4
`define ITT_MASK_OFS 12'h0A8
`define ITT_CTRL_RESET 8'h00
`define ITT_SYSTEM_CLOCK_GENERATOR_CONTROL_RESET 3'h0
`define ITT_FLAG_BIT 7
`define ITT_EN_BIT 6
`define ITT_CLR_BIT 5
`define ITT_SEL_MSB 2
`define ITT_SEL_LSB 0
`define ITT_DIV_MSB 2
`define ITT_DIV_LSB 0
`define ITT_TICKCLR_BIT 3
`define ITT_EV_W 2
`define ITT_EV_IVL_BIT 0
`define ITT_EV_100_BIT 1
`define ITT_TICK_OSC_DIV 8'h80
`define ITT_LONG_TICKS 5'h13
`define ITT_SHORT_TICKS 5'h12
`define ITT_SHORT_PHASE 2'h3
`define ITT_UNIT_HALF_TICKS 6'h19
`define ITT_UNIT_NUM_US 200
`define ITT_UNIT_DEN 3
`define ITT_IVL_400_US 400
`define ITT_IVL_800_US 800
`define ITT_IVL_1MS_US 1000
`define ITT_IVL_2MS_US 2000
`define ITT_IVL_5MS_US 5000
`endif

// ===== itt_chk.sv
// Port-level assertion checker for the interval tick timer.
`default_nettype none
module itt_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic tick_pulse,
	input wire logic pulse_100us
);
	logic [2:0] div;
	logic en;
	logic [15:0] tgap, pgap;
	wire logic wr = psel && penable && pready && pwrite && pstrb[0];
	wire logic [15:0] per = 16'h0080 >> div;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Gaps restart on any write, so only spacing under a settled setup is judged.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 3'h0;
			en <= 1'b0;
			tgap <= 16'h0000;
			pgap <= 16'h0000;
		end else begin
			if (wr && paddr == 12'h0A0) div <= pwdata[2:0];
			if (wr && paddr == 12'h09C) en <= pwdata[6];
			tgap <= (psel && pwrite) ? 16'h0000 : tick_pulse ? 16'h0001 : tgap + {15'h0000, tgap != 16'h0000};
			pgap <= (psel && pwrite) ? 16'h0000 : pulse_100us ? 16'h0001 : pgap + {15'h0000, pgap != 16'h0000};
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	property p_one_wait; s_setup ##1 s_wait |=> pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("ready late");
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
	property p_rsvd; psel && penable && pready && !pwrite && paddr == 12'h09C
		|-> prdata[31:8] == 24'h000000 && prdata[5:3] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("control spare bits set");
	property p_tick_rate; tick_pulse && tgap != 16'h0000 |-> tgap == per; endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("tick spacing wrong");
	property p_p100_gap; pulse_100us && pgap != 16'h0000 |-> pgap == per * 16'h0013 || pgap == per * 16'h0012;
	endproperty
	a_p100_gap: assert property (p_p100_gap) else $error("100 us spacing wrong");
	property p_p100_one; pulse_100us |=> !pulse_100us; endproperty
	a_p100_one: assert property (p_p100_one) else $error("100 us pulse too long");
	property p_idle_tick; !en && !$past(en) && !$past(en, 2) |-> !tick_pulse; endproperty
	a_idle_tick: assert property (p_idle_tick) else $error("tick while disabled");
	property p_reset_quiet; $rose(presetn) |-> !irq && !tick_pulse && !pulse_100us; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
endmodule : itt_chk
bind interval_tick_timer itt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .tick_pulse(tick_pulse), .pulse_100us(pulse_100us));
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the interval tick timer.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_d = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h20, d;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, irq, tick_pulse, pulse_100us;
	logic [64:0] q_rd[$], e;
	int q_lo[$], q_hi[$];
	int n_mismatch = 0, checked = 0, cyc = 0, last = 0, lo, hi, k, s, n;
	always #12.5 pclk = ~pclk;
	interval_tick_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .tick_pulse(tick_pulse), .pulse_100us(pulse_100us));
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction : xs
	task automatic step(input int i);
		if (i > 3000) begin
			n_mismatch++;
			give_verdict();
		end
		@(posedge pclk);
	endtask : step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [3:0] st);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; pready !== 1'b1; i++) step(i);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] dd);
		apb(1'b1, a, dd, 4'hF);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] m, v, input logic er);
		q_rd.push_back({er, m, v});
		apb(1'b0, a, 32'h0, 4'hF);
	endtask : rd
	task automatic cnt(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge pclk);
			c += tick_pulse;
		end
	endtask : cnt
	task automatic wev();
		int i;
		for (i = 0; irq !== 1'b0; i++) step(i);
		for (i = 0; irq !== 1'b1; i++) step(i);
		rd(12'h0A4, 32'h1, 32'h1, 1'b0);
	endtask : wev
	// Each read note is matched in order; irq rises are spaced against the gap notes.
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready && !pwrite) begin
			e = q_rd.pop_front();
			chk("read data", e[31:0], prdata & e[63:32]);
			chk("read error", {31'h0, e[64]}, {31'h0, pslverr});
		end
		if (irq && !irq_d) begin
			if (last != 0 && q_lo.size() > 0) begin
				lo = q_lo.pop_front();
				hi = q_hi.pop_front();
				chk("interval gap", lo, (cyc - last == hi) ? lo : cyc - last);
			end
			last = cyc;
		end
		irq_d = irq;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 4; k++) rd(12'h09C + 12'(4 * k), 32'hFFFFFFFF, 32'h0, 1'b0);
		rd(12'h0B0, 32'hFFFFFFFF, 32'h0, 1'b1);
		d = xs();
		wr(12'h09C, d);
		rd(12'h09C, 32'hFFFFFFFF, d & 32'h47, 1'b0);
		apb(1'b1, 12'h09C, ~d, 4'hE);
		rd(12'h09C, 32'hFFFFFFFF, d & 32'h47, 1'b0);
		for (k = 0; k < 3; k++) begin
			wr(12'h0A0, 32'(k * k + k));
			wr(12'h09C, 32'h40);
			cnt(10 * (128 >> (k * k + k)), n);
			chk("tick count", 32'hA, n);
			wr(12'h0A0, xs() & 32'h7);
			repeat (300) @(posedge pclk);
		end
		wr(12'h09C, 32'h0);
		cnt(300, n);
		chk("tick count", 32'h0, n);
		wr(12'h0A0, 32'h7);
		wr(12'h0A8, 32'h1);
		for (s = 1; s < 8; s++) begin
			wr(12'h09C, 32'h0);
			rd(12'h0A4, 32'h0, 32'h0, 1'b0);
			wr(12'h0A0, 32'hF);
			wr(12'h09C, 32'h60 | s);
			wr(12'h0A0, 32'hF);
			last = 0;
			case (s)
				1: q_lo = {19, 19, 18, 19};
				2: q_lo = {37, 38, 37};
				3: q_lo = {75, 75};
				4: q_lo = {150, 150};
				5: q_lo = {187, 187};
				6: q_lo = {375};
				default: q_lo = {937};
			endcase
			q_hi = q_lo;
			foreach (q_hi[i]) q_hi[i] += (s == 5 || s == 7);
			repeat (q_lo.size() + 1) wev();
		end
		wr(12'h09C, 32'h41);
		wr(12'h0A8, 32'h0);
		repeat (40) @(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(12'h0A8, 32'h1);
		repeat (3) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(12'h09C, 32'h81);
		rd(12'h09C, 32'hFF, 32'h81, 1'b0);
		wr(12'h09C, 32'h01);
		rd(12'h09C, 32'hFF, 32'h01, 1'b0);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire

// ===== tick_gen.sv
// Constant-rate tick generator clocked by the divided system clock.
`include "interval_tick_timer_regs.svh"
`default_nettype none
module tick_gen #(
	parameter int CNT_W = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic clear,
	input wire logic [2:0] div_sel,
	output logic tick,
	output logic [1:0] half_step
);
	logic [CNT_W-1:0] cnt_reg;
	// Terminal count shrinks as the system clock is divided further.
	wire [CNT_W-1:0] term = CNT_W'((`ITT_TICK_OSC_DIV >> div_sel) - 8'h01);
	wire at_end = cnt_reg >= term;
	wire at_mid = (cnt_reg == (term >> 1)) && (term != '0);
	assign tick = run & at_end & ~clear;
	// At the deepest division one cycle is one tick, so it counts as two half ticks.
	assign half_step = (!run || clear) ? 2'h0 : (term == '0) ? 2'h2 : (at_end | at_mid) ? 2'h1 : 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (clear) begin
			cnt_reg <= '0;
		end else if (run) begin
			cnt_reg <= at_end ? '0 : cnt_reg + 1'b1;
		end
	end
endmodule : tick_gen
`default_nettype wire
